// file: rtl/hwm_core.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - One converter result path; every analog channel stored as an 8-bit value.
// - Results outside high or low limits set sticky status bits feeding two masked outputs.
// - Self-test RAM of 32 bytes; pointer advances after each access.
// - External over-temperature input sets a status bit in the same interrupt system.
// - Three tach inputs are each timed and compared against a limit.
// - Read data drive the data lines only after a selected read strobe.
// - A selected write strobe captures the data lines as a write.
// - All timing derives from the bus clock; logic works at any slow rate.
// - Eight data lines, bit 0 least significant, bit 7 most significant.
// - Chained interrupt input reaches the management output via mask bit 6 and enable.
// - A high intrusion line latches an intrusion event.
// - Mask-2 bit 7 drives intrusion low for 20 ms and clears the latch.
// - Management output stays inactive unless configuration bit 1 is set; reset disables.
// - Configuration bit 5 picks NMI or IRQ mode; bit 2 enables; reset disables.
module hwm_core
  import hwm_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYC,
  parameter int FAN_TICK_CYCLES = FAN_TICK_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Host port.
  input wire hwm_isa_in_t isa_i,
  output hwm_dbus_t isa_data_o,
  // Converter.
  output logic adc_start_o,
  output logic [2:0] adc_chan_o,
  input wire logic adc_done_i,
  input wire logic [7:0] adc_result_i,
  // Monitored digital inputs.
  input wire logic [NUM_FAN-1:0] fan_tach_i,
  input wire logic board_overtemp_in_n_i,
  input wire logic chained_mgmt_irq_in_n_i,
  // Intrusion line, open drain.
  input wire logic intrusion_i,
  output hwm_pin_t intrusion_o,
  // Interrupt outputs.
  output hwm_pin_t mgmt_irq_out_o,
  output hwm_pin_t irq2_o
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int TW = $clog2(FAN_TICK_CYCLES + 1);
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_START = 3'b010,
    SEQ_WAIT = 3'b100
  } hwm_seq_t;
  hwm_seq_t seq_reg;
  logic [2:0] chan_reg;
  logic [6:0] index_reg;
  logic [7:0] cfg_reg;
  logic [7:0] stat1_reg;
  logic [7:0] stat2_reg;
  logic [7:0] mmask1_reg;
  logic [7:0] mmask2_reg;
  logic [7:0] imask1_reg;
  logic [7:0] imask2_reg;
  logic [7:0] result_reg [NUM_ANALOG];
  logic [7:0] limit_hi_reg [NUM_ANALOG];
  logic [7:0] limit_lo_reg [NUM_ANALOG];
  logic [7:0] fanlim_reg [NUM_FAN];
  logic [7:0] fan_count [NUM_FAN];
  logic [NUM_FAN-1:0] fan_done;
  logic [NUM_FAN-1:0] fan_viol;
  logic [PW-1:0] pulse_cnt_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic fan_tick;
  logic chain_s1_reg;
  logic chain_s2_reg;
  logic intr_s1_reg;
  logic intr_s2_reg;
  logic rd_req;
  logic wr_req;
  logic drd;
  logic dwr;
  logic ram_rd;
  logic ram_wr;
  logic [7:0] ram_rdata;
  logic [7:0] rd_val;
  logic [6:0] off_res;
  logic [6:0] off_fan;
  logic [6:0] off_lim;
  logic [6:0] off_flim;
  logic conv_done;
  logic conv_viol;
  logic pulse_active;
  logic pulse_start;
  logic pulse_end;
  logic [7:0] set1;
  logic [7:0] set2;
  logic mgmt_cause;
  logic irq2_cause;
  // Host strobes: select qualifies each strobe; decoding of upper bits is outside.
  assign rd_req = ~isa_i.cs_n & ~isa_i.iord_n;
  assign wr_req = ~isa_i.cs_n & ~isa_i.iowr_n;
  assign drd = rd_req && isa_i.addr == PORT_DATA;
  assign dwr = wr_req && isa_i.addr == PORT_DATA;
  assign ram_rd = rd_req && isa_i.addr == PORT_SELFTEST;
  assign ram_wr = wr_req && isa_i.addr == PORT_SELFTEST;
  assign off_res = 7'(index_reg - REG_RESULT_BASE);
  assign off_fan = 7'(index_reg - REG_FAN_BASE);
  assign off_lim = 7'(index_reg - REG_LIMIT_BASE);
  assign off_flim = 7'(index_reg - REG_FANLIM_BASE);
  // Read multiplexer over the indexed map.
  always_comb begin
    rd_val = UNMAPPED_RD;
    if (index_reg == REG_CONFIG) begin
      rd_val = cfg_reg;
    end else if (index_reg == REG_STAT1) begin
      rd_val = stat1_reg;
    end else if (index_reg == REG_STAT2) begin
      rd_val = stat2_reg;
    end else if (index_reg == REG_MMASK1) begin
      rd_val = mmask1_reg;
    end else if (index_reg == REG_MMASK2) begin
      rd_val = mmask2_reg;
    end else if (index_reg == REG_IMASK1) begin
      rd_val = imask1_reg;
    end else if (index_reg == REG_IMASK2) begin
      rd_val = imask2_reg;
    end else if (off_res < 7'(NUM_ANALOG)) begin
      rd_val = result_reg[off_res[2:0]];
    end else if (off_fan < 7'(NUM_FAN)) begin
      rd_val = fan_count[off_fan[1:0]];
    end else if (off_lim < 7'(2 * NUM_ANALOG)) begin
      rd_val = off_lim[0] ? limit_lo_reg[off_lim[3:1]] : limit_hi_reg[off_lim[3:1]];
    end else if (off_flim < 7'(NUM_FAN)) begin
      rd_val = fanlim_reg[off_flim[1:0]];
    end
  end

  // Read data and its enable stand in the cycle after the read strobe.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      isa_data_o <= '0;
    end else begin
      isa_data_o.oe <= rd_req;
      if (rd_req) begin
        unique case (isa_i.addr)
          PORT_SELFTEST: isa_data_o.data <= ram_rdata;
          PORT_INDEX: isa_data_o.data <= {1'b0, index_reg};
          PORT_DATA: isa_data_o.data <= rd_val;
          default: isa_data_o.data <= UNMAPPED_RD;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      index_reg <= '0;
    end else if (wr_req && isa_i.addr == PORT_INDEX) begin
      index_reg <= isa_i.data[6:0];
    end
  end
  hwm_selftest_ram #(
    .DEPTH(RAM_DEPTH),
    .WIDTH(DATA_W)
  ) u_ram (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .wr_i(ram_wr),
    .rd_i(ram_rd),
    .wdata_i(isa_i.data),
    .rdata_o(ram_rdata)
  );

  // Configuration, masks and limits written through the data port.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_reg <= CONFIG_RST;
      mmask1_reg <= MASK_RST;
      mmask2_reg <= MASK_RST;
      imask1_reg <= MASK_RST;
    end else if (dwr) begin
      if (index_reg == REG_CONFIG) cfg_reg <= isa_i.data;
      if (index_reg == REG_MMASK1) mmask1_reg <= isa_i.data;
      if (index_reg == REG_MMASK2) mmask2_reg <= isa_i.data;
      if (index_reg == REG_IMASK1) imask1_reg <= isa_i.data;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_ANALOG; i++) begin
        limit_hi_reg[i] <= LIMIT_HI_RST;
        limit_lo_reg[i] <= LIMIT_LO_RST;
      end
      for (int i = 0; i < NUM_FAN; i++) begin
        fanlim_reg[i] <= FANLIM_RST;
      end
    end else if (dwr) begin
      if (off_lim < 7'(2 * NUM_ANALOG)) begin
        if (off_lim[0]) begin
          limit_lo_reg[off_lim[3:1]] <= isa_i.data;
        end else begin
          limit_hi_reg[off_lim[3:1]] <= isa_i.data;
        end
      end
      if (off_flim < 7'(NUM_FAN)) fanlim_reg[off_flim[1:0]] <= isa_i.data;
    end
  end

  // Conversion sequencer walks the channels while monitoring is started.
  assign adc_start_o = seq_reg == SEQ_START;
  assign adc_chan_o = chan_reg;
  assign conv_done = seq_reg == SEQ_WAIT && adc_done_i;
  assign conv_viol = adc_result_i > limit_hi_reg[chan_reg] || adc_result_i < limit_lo_reg[chan_reg];
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_reg <= SEQ_IDLE;
      chan_reg <= '0;
    end else begin
      unique case (seq_reg)
        SEQ_IDLE: if (cfg_reg[CFG_START_BIT]) seq_reg <= SEQ_START;
        SEQ_START: seq_reg <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (adc_done_i) begin
            seq_reg <= SEQ_IDLE;
            chan_reg <= chan_reg + 3'h1;
          end
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_ANALOG; i++) begin
        result_reg[i] <= '0;
      end
    end else if (conv_done) begin
      result_reg[chan_reg] <= adc_result_i;
    end
  end

  // Fan timing tick; a plain cycle divider, so any clock rate keeps working.
  assign fan_tick = tick_cnt_reg == TW'(FAN_TICK_CYCLES - 1);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= fan_tick ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
    hwm_fan_tach #(
      .WIDTH(DATA_W)
    ) u_tach (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .tick_i(fan_tick),
      .tach_i(fan_tach_i[f]),
      .count_o(fan_count[f]),
      .done_o(fan_done[f])
    );
    assign fan_viol[f] = fan_done[f] && fan_count[f] > fanlim_reg[f];
  end

  // Two-stage synchronisers for the chained and intrusion inputs.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chain_s1_reg <= 1'b1;
      chain_s2_reg <= 1'b1;
      intr_s1_reg <= 1'b0;
      intr_s2_reg <= 1'b0;
    end else begin
      chain_s1_reg <= chained_mgmt_irq_in_n_i;
      chain_s2_reg <= chain_s1_reg;
      intr_s1_reg <= intrusion_i;
      intr_s2_reg <= intr_s1_reg;
    end
  end

  // Sticky status; a set in the cycle of a clearing read survives.
  assign set1 = conv_done && conv_viol ? 8'(8'h01 << chan_reg) : 8'h00;
  assign set2 = {3'b000, intr_s2_reg, ~board_overtemp_in_n_i, fan_viol};
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat1_reg <= '0;
    end else if (drd && index_reg == REG_STAT1) begin
      stat1_reg <= set1;
    end else begin
      stat1_reg <= stat1_reg | set1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat2_reg <= '0;
    end else begin
      if (drd && index_reg == REG_STAT2) begin
        stat2_reg[STAT2_BTI_BIT:0] <= set2[STAT2_BTI_BIT:0];
      end else begin
        stat2_reg[STAT2_BTI_BIT:0] <= stat2_reg[STAT2_BTI_BIT:0] | set2[STAT2_BTI_BIT:0];
      end
      if (pulse_start || pulse_active) begin
        stat2_reg[STAT2_INTR_BIT] <= 1'b0;
      end else if (set2[STAT2_INTR_BIT]) begin
        stat2_reg[STAT2_INTR_BIT] <= 1'b1;
      end
    end
  end

  // Intrusion clearing pulse of at least the documented width.
  assign pulse_active = pulse_cnt_reg != '0;
  assign pulse_start = dwr && index_reg == REG_IMASK2 && isa_i.data[MASK2_INTR_CLR_BIT] && !pulse_active;
  assign pulse_end = pulse_cnt_reg == PW'(1);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cnt_reg <= '0;
    end else if (pulse_start) begin
      pulse_cnt_reg <= PW'(PULSE_CYCLES);
    end else if (pulse_active) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      imask2_reg <= MASK_RST;
    end else if (dwr && index_reg == REG_IMASK2) begin
      imask2_reg[6:0] <= isa_i.data[6:0];
      imask2_reg[MASK2_INTR_CLR_BIT] <= isa_i.data[MASK2_INTR_CLR_BIT] | (pulse_active && !pulse_end);
    end else if (pulse_end) begin
      imask2_reg[MASK2_INTR_CLR_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      intrusion_o <= '0;
    end else begin
      intrusion_o.o <= 1'b0;
      intrusion_o.oe <= pulse_start || (pulse_active && !pulse_end);
    end
  end

  // Interrupt outputs.
  assign mgmt_cause = |(stat1_reg & ~mmask1_reg) || |(stat2_reg[4:0] & ~mmask2_reg[4:0])
    || (!chain_s2_reg && !mmask2_reg[MASK2_CHAIN_BIT]);
  assign irq2_cause = |(stat1_reg & ~imask1_reg) || |(stat2_reg[4:0] & ~imask2_reg[4:0]);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_irq_out_o <= '0;
      irq2_o <= '0;
    end else begin
      mgmt_irq_out_o.o <= 1'b0;
      mgmt_irq_out_o.oe <= cfg_reg[CFG_MGMT_EN_BIT] && mgmt_cause;
      irq2_o.o <= cfg_reg[CFG_NMI_MODE_BIT];
      irq2_o.oe <= cfg_reg[CFG_IRQ2_EN_BIT] && irq2_cause;
    end
  end

endmodule : hwm_core
`default_nettype wire

// file: rtl/hwm_pkg.sv
package hwm_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_MS = 20;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAN_TICK_NS = 22500;
  localparam int FAN_TICK_CYC = (FAN_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sizes.
  localparam int NUM_ANALOG = 8;
  localparam int NUM_FAN = 3;
  localparam int RAM_DEPTH = 32;
  localparam int DATA_W = 8;

  // Host port offsets on the three address lines.
  localparam logic [2:0] PORT_SELFTEST = 3'h0;
  localparam logic [2:0] PORT_INDEX = 3'h5;
  localparam logic [2:0] PORT_DATA = 3'h6;

  // Indexed register map.
  localparam logic [6:0] REG_RESULT_BASE = 7'h20;
  localparam logic [6:0] REG_FAN_BASE = 7'h28;
  localparam logic [6:0] REG_LIMIT_BASE = 7'h30;
  localparam logic [6:0] REG_CONFIG = 7'h40;
  localparam logic [6:0] REG_STAT1 = 7'h41;
  localparam logic [6:0] REG_STAT2 = 7'h42;
  localparam logic [6:0] REG_MMASK1 = 7'h43;
  localparam logic [6:0] REG_MMASK2 = 7'h44;
  localparam logic [6:0] REG_IMASK1 = 7'h45;
  localparam logic [6:0] REG_IMASK2 = 7'h46;
  localparam logic [6:0] REG_FANLIM_BASE = 7'h50;

  // Field positions.
  localparam int CFG_START_BIT = 0;
  localparam int CFG_MGMT_EN_BIT = 1;
  localparam int CFG_IRQ2_EN_BIT = 2;
  localparam int CFG_NMI_MODE_BIT = 5;
  localparam int MASK2_CHAIN_BIT = 6;
  localparam int MASK2_INTR_CLR_BIT = 7;
  localparam int STAT2_BTI_BIT = 3;
  localparam int STAT2_INTR_BIT = 4;

  // Reset values.
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] LIMIT_HI_RST = 8'hFF;
  localparam logic [7:0] LIMIT_LO_RST = 8'h00;
  localparam logic [7:0] FANLIM_RST = 8'hFF;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  typedef struct packed {
    logic cs_n;
    logic iord_n;
    logic iowr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } hwm_isa_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } hwm_dbus_t;

  typedef struct packed {
    logic o;
    logic oe;
  } hwm_pin_t;

endpackage : hwm_pkg

// file: rtl/hwm_selftest_ram.sv
`timescale 1ns/1ps
`default_nettype none
module hwm_selftest_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Access strobes and data.
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] ptr_reg;

  assign rdata_o = mem_reg[ptr_reg];

  // The pointer steps after every access and wraps at the top.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_reg <= '0;
    end else if (wr_i || rd_i) begin
      ptr_reg <= (ptr_reg == AW'(DEPTH - 1)) ? '0 : ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_i) begin
      mem_reg[ptr_reg] <= wdata_i;
    end
  end

endmodule : hwm_selftest_ram
`default_nettype wire

// file: rtl/hwm_fan_tach.sv
`timescale 1ns/1ps
`default_nettype none
module hwm_fan_tach #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Measurement.
  input wire logic tick_i,
  input wire logic tach_i,
  output logic [WIDTH-1:0] count_o,
  output logic done_o
);

  logic tach_prev_reg;
  logic [WIDTH-1:0] acc_reg;
  logic rise;

  assign rise = tach_i & ~tach_prev_reg;

  // Ticks between two rising tach edges, saturating at all ones.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tach_prev_reg <= 1'b0;
      acc_reg <= '0;
      count_o <= '0;
      done_o <= 1'b0;
    end else begin
      tach_prev_reg <= tach_i;
      done_o <= rise;
      if (rise) begin
        count_o <= acc_reg;
        acc_reg <= '0;
      end else if (tick_i && acc_reg != '1) begin
        acc_reg <= acc_reg + 1'b1;
      end
    end
  end

endmodule : hwm_fan_tach
`default_nettype wire

// file: dv/hwm_isa_host.sv
`timescale 1ns/1ps
`default_nettype none
module hwm_isa_host
  import hwm_pkg::*;
(
  // Clock.
  input wire logic mclk_i,
  // Host bus.
  output var hwm_isa_in_t isa_o,
  input wire hwm_dbus_t dev_i
);
  hwm_isa_in_t drv = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
  // The device wins the data lines while it drives them.
  always_comb begin
    isa_o = drv;
    if (dev_i.oe)
      isa_o.data = dev_i.data;
  end
  // Released data lines show the inverse of the last value.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    drv <= '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    drv <= '{1'b1, 1'b1, 1'b1, 3'h0, ~d};
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    drv <= '{1'b0, 1'b0, 1'b1, a, ~drv.data};
    @(posedge mclk_i);
    drv <= '{1'b1, 1'b1, 1'b1, 3'h0, ~drv.data};
    @(negedge mclk_i);
    d = dev_i.oe ? isa_o.data : 8'hXX;
  endtask : rd
endmodule : hwm_isa_host
`default_nettype wire

// file: dv/hwm_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hwm_core_monitor
  import hwm_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYC,
  parameter int FAN_TICK_CYCLES = FAN_TICK_CYC
) (
  // Clock, reset and host port.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire hwm_isa_in_t isa_i,
  input wire hwm_dbus_t isa_data_o,
  // Converter and monitored inputs.
  input wire logic adc_start_o,
  input wire logic [2:0] adc_chan_o,
  input wire logic adc_done_i,
  input wire logic [7:0] adc_result_i,
  input wire logic [NUM_FAN-1:0] fan_tach_i,
  input wire logic board_overtemp_in_n_i,
  input wire logic chained_mgmt_irq_in_n_i,
  // Pins.
  input wire logic intrusion_i,
  input wire hwm_pin_t intrusion_o,
  input wire hwm_pin_t mgmt_irq_out_o,
  input wire hwm_pin_t irq2_o
);
  default clocking mon_cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic wr_sel;
  logic rd_sel;
  logic [6:0] idx_reg;
  logic [7:0] cfg_reg;
  logic [7:0] mm2_reg;
  logic [31:0] pulse_reg;
  assign wr_sel = !isa_i.cs_n && !isa_i.iowr_n;
  assign rd_sel = !isa_i.cs_n && !isa_i.iord_n;
  // Shadows the index, configuration and management mask 2 registers.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_reg <= 7'h00;
      cfg_reg <= CONFIG_RST;
      mm2_reg <= MASK_RST;
    end else if (wr_sel && isa_i.addr == PORT_INDEX) begin
      idx_reg <= isa_i.data[6:0];
    end else if (wr_sel && isa_i.addr == PORT_DATA && idx_reg == REG_CONFIG) begin
      cfg_reg <= isa_i.data;
    end else if (wr_sel && isa_i.addr == PORT_DATA && idx_reg == REG_MMASK2) begin
      mm2_reg <= isa_i.data;
    end
  end
  // Counts the cycles of the current intrusion pull.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      pulse_reg <= 32'h0;
    else
      pulse_reg <= intrusion_o.oe ? pulse_reg + 32'h1 : 32'h0;
  end
  a_read_drives: assert property (rd_sel |=> isa_data_o.oe)
    else $error("data lines not driven after a read");
  a_drive_cause: assert property (isa_data_o.oe |-> $past(rd_sel))
    else $error("data lines driven without a read");
  a_od_low: assert property (!intrusion_o.o && !mgmt_irq_out_o.o)
    else $error("open drain pin drives high");
  a_mgmt_off: assert property (!cfg_reg[CFG_MGMT_EN_BIT] [*3] |-> !mgmt_irq_out_o.oe)
    else $error("management output active while disabled");
  a_irq2_off: assert property (!cfg_reg[CFG_IRQ2_EN_BIT] [*3] |-> !irq2_o.oe)
    else $error("second output active while disabled");
  a_irq2_mode: assert property (irq2_o.o == $past(cfg_reg[CFG_NMI_MODE_BIT]))
    else $error("second output level does not follow mode");
  a_chain_path: assert property ((!chained_mgmt_irq_in_n_i && cfg_reg[1] && !mm2_reg[6]) [*5]
    |-> mgmt_irq_out_o.oe) else $error("chained interrupt not passed on");
  a_intr_start: assert property (wr_sel && isa_i.addr == PORT_DATA && idx_reg == REG_IMASK2
    && isa_i.data[7] |=> intrusion_o.oe) else $error("intrusion pull did not start");
  a_intr_len: assert property ($fell(intrusion_o.oe) |-> pulse_reg == PULSE_CYCLES)
    else $error("intrusion pull has wrong length");
  a_chan_step: assert property ($changed(adc_chan_o) |-> $past(adc_done_i)
    && adc_chan_o == $past(adc_chan_o) + 3'h1) else $error("channel step wrong");
  c_read: cover property (rd_sel ##1 isa_data_o.oe);
  c_pulse: cover property ($fell(intrusion_o.oe));
  c_chain: cover property (mgmt_irq_out_o.oe);
  c_nmi: cover property (irq2_o.oe && irq2_o.o);
endmodule : hwm_core_monitor
bind hwm_core hwm_core_monitor #(.PULSE_CYCLES(PULSE_CYCLES), .FAN_TICK_CYCLES(FAN_TICK_CYCLES)) u_mon (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .isa_i(isa_i), .isa_data_o(isa_data_o),
  .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i), .adc_result_i(adc_result_i),
  .fan_tach_i(fan_tach_i), .board_overtemp_in_n_i(board_overtemp_in_n_i),
  .chained_mgmt_irq_in_n_i(chained_mgmt_irq_in_n_i), .intrusion_i(intrusion_i), .intrusion_o(intrusion_o),
  .mgmt_irq_out_o(mgmt_irq_out_o), .irq2_o(irq2_o));
`default_nettype wire

// file: dv/hwm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hwm_core_tb
  import hwm_pkg::*;
;
  localparam int PULSE = 20;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  hwm_isa_in_t isa;
  hwm_dbus_t dbus;
  hwm_pin_t intr_o, mgmt, irq2;
  logic adc_start;
  logic adc_done = 1'b0;
  logic [2:0] chan;
  logic [7:0] adc_res = 8'h00;
  logic [7:0] fcnt = 8'h00;
  logic bti_n = 1'b1;
  logic chain_n = 1'b1;
  logic intr_drv = 1'b0;
  logic intr_line;
  logic [2:0] flags;
  logic [7:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  always #5 mclk_i = ~mclk_i;
  // The device pull wins over the external high on the intrusion line.
  assign intr_line = intr_drv & ~intr_o.oe;
  assign flags = {intr_o.oe, mgmt.oe, irq2.oe};
  // Tach periods of 256, 128 and 64 cycles.
  always @(posedge mclk_i) fcnt <= fcnt + 8'h01;
  // The converter answers one cycle after a start; channel 0 reads high.
  always @(posedge mclk_i) begin
    adc_done <= adc_start;
    adc_res <= (chan == 3'h0) ? 8'h90 : 8'h10;
  end
  hwm_isa_host u_host (.mclk_i(mclk_i), .isa_o(isa), .dev_i(dbus));
  hwm_core #(.PULSE_CYCLES(PULSE), .FAN_TICK_CYCLES(4)) u_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .isa_i(isa), .isa_data_o(dbus), .adc_start_o(adc_start),
    .adc_chan_o(chan), .adc_done_i(adc_done), .adc_result_i(adc_res), .fan_tach_i(fcnt[7:5]),
    .board_overtemp_in_n_i(bti_n), .chained_mgmt_irq_in_n_i(chain_n), .intrusion_i(intr_line),
    .intrusion_o(intr_o), .mgmt_irq_out_o(mgmt), .irq2_o(irq2));
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_flag(input int b, input logic v);
    for (int i = 0; i < 1000 && flags[b] !== v; i++)
      @(negedge mclk_i);
    if (flags[b] !== v) begin
      num_errors++;
      $display("mismatch flag %0d expected %b seen %b", b, v, flags[b]);
      stop_test;
    end
  endtask : wait_flag
  task automatic wreg(input logic [6:0] idx, input logic [7:0] v);
    u_host.wr(PORT_INDEX, {1'b0, idx});
    u_host.wr(PORT_DATA, v);
  endtask : wreg
  task automatic rreg(input logic [6:0] idx, output logic [7:0] v);
    u_host.wr(PORT_INDEX, {1'b0, idx});
    u_host.rd(PORT_DATA, v);
  endtask : rreg
  task automatic t_reset;
    rreg(REG_CONFIG, rd);
    chk("config", rd, CONFIG_RST);
    chk("irq_pins", {6'h0, mgmt.oe, irq2.oe}, 8'h00);
  endtask : t_reset
  task automatic t_regs;
    u_host.wr(PORT_INDEX, 8'hB0);
    u_host.rd(PORT_INDEX, rd);
    chk("index", rd, 8'h30);
    u_host.wr(PORT_DATA, 8'h5A);
    u_host.rd(PORT_DATA, rd);
    chk("limit", rd, 8'h5A);
    rreg(7'h7F, rd);
    chk("unmapped", rd, UNMAPPED_RD);
    u_host.rd(3'h3, rd);
    chk("bad_port", rd, 8'h00);
  endtask : t_regs
  task automatic t_ram;
    for (int i = 0; i < RAM_DEPTH; i++)
      u_host.wr(PORT_SELFTEST, 8'(i) ^ 8'h3C);
    for (int i = 0; i < RAM_DEPTH; i++) begin
      u_host.rd(PORT_SELFTEST, rd);
      chk("ram", rd, 8'(i) ^ 8'h3C);
    end
  endtask : t_ram
  task automatic t_adc;
    wreg(REG_LIMIT_BASE, 8'h80);
    wreg(REG_CONFIG, 8'h25);
    wait_flag(0, 1'b1);
    chk("nmi_level", {7'h0, irq2.o}, 8'h01);
    wreg(REG_CONFIG, 8'h04);
    rreg(REG_RESULT_BASE, rd);
    chk("result0", rd, 8'h90);
    rreg(REG_RESULT_BASE + 7'h1, rd);
    chk("result1", rd, 8'h10);
    wreg(REG_IMASK1, 8'h01);
    wait_flag(0, 1'b0);
    rreg(REG_STAT1, rd);
    chk("stat1", rd, 8'h01);
    rreg(REG_STAT1, rd);
    chk("stat1_clr", rd, 8'h00);
    wreg(REG_IMASK1, MASK_RST);
  endtask : t_adc
  task automatic t_fan;
    wreg(REG_FANLIM_BASE, 8'h01);
    wait_flag(0, 1'b1);
    chk("irq_level", {7'h0, irq2.o}, 8'h00);
    rreg(REG_STAT2, rd);
    chk("fan_stat", rd & 8'h07, 8'h01);
    wreg(REG_FANLIM_BASE, FANLIM_RST);
  endtask : t_fan
  task automatic t_chain;
    wreg(REG_CONFIG, 8'h00);
    wreg(REG_MMASK1, 8'hFF);
    wreg(REG_MMASK2, 8'hBF);
    chain_n <= 1'b0;
    repeat (8) @(negedge mclk_i);
    chk("mgmt_off", {7'h0, mgmt.oe}, 8'h00);
    wreg(REG_CONFIG, 8'h02);
    wait_flag(1, 1'b1);
    wreg(REG_MMASK2, 8'hFF);
    wait_flag(1, 1'b0);
    chain_n <= 1'b1;
  endtask : t_chain
  task automatic t_intr;
    int n;
    wreg(REG_CONFIG, 8'h00);
    intr_drv <= 1'b1;
    bti_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    intr_drv <= 1'b0;
    bti_n <= 1'b1;
    rreg(REG_STAT2, rd);
    chk("stat2", rd & 8'h18, 8'h18);
    rreg(REG_STAT2, rd);
    chk("intr_held", rd & 8'h18, 8'h10);
    wreg(REG_IMASK2, 8'h80);
    wait_flag(2, 1'b1);
    n = 0;
    while (intr_o.oe === 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    chk("pulse_len", 8'(n), 8'(PULSE));
    rreg(REG_STAT2, rd);
    chk("intr_clr", rd & 8'h10, 8'h00);
    rreg(REG_IMASK2, rd);
    chk("imask2", rd, 8'h00);
  endtask : t_intr
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_ram;
    t_adc;
    t_fan;
    t_chain;
    t_intr;
    stop_test;
  end
endmodule : hwm_core_tb
`default_nettype wire
